// *** verilog/pc_card_timing_regs.vh ***
`ifndef PC_CARD_TIMING_REGS_VH
`define PC_CARD_TIMING_REGS_VH

// Byte offsets of the register port.
`define AREA5_BUS_TIMING_REG_OFS 8'h00
`define AREA6_BUS_TIMING_REG_OFS 8'h04
`define ACCESS_STATUS_REG_OFS 8'h08

// Field positions inside a bus timing register.
`define STROBE_SETUP_DELAY_MSB 14
`define STROBE_SETUP_DELAY_LSB 11
`define ACCESS_WAIT_COUNT_MSB 10
`define ACCESS_WAIT_COUNT_LSB 7
`define EXT_WAIT_MASK_BIT 6
`define ADDR_HOLD_AFTER_STROBE_MSB 3
`define ADDR_HOLD_AFTER_STROBE_LSB 0

// Reset value and writable-bit mask.
`define BUS_TIMING_REG_RESET 32'h00000500
`define BUS_TIMING_REG_WRITE_MASK 32'h00007fcf

// Highest strobe set-up delay code that is not prohibited.
`define STROBE_SETUP_DELAY_MAX 4'h7

// Bus clock period in ns and the core clock period in ns.
`define BUS_CLK_PERIOD_NS 20
`define CORE_CLK_PERIOD_NS 10
// Core clock cycles in one half bus cycle.
`define HALF_CYCLE_TICKS (`BUS_CLK_PERIOD_NS / 2 / `CORE_CLK_PERIOD_NS)

`endif

// *** verilog/wait_count_table.v ***
`timescale 1ns/1ps
`include "pc_card_timing_regs.vh"

module wait_count_table (
	input wire core_clk,
	input wire arst_n,
	input wire [3:0] code,
	output reg [6:0] cycles_q
);

	reg [6:0] cycles_d;

	always @* begin
		case (code) // (R1)
		4'h0: cycles_d = 7'd3;
		4'h1: cycles_d = 7'd6;
		4'h2: cycles_d = 7'd9;
		4'h3: cycles_d = 7'd12;
		4'h4: cycles_d = 7'd15;
		4'h5: cycles_d = 7'd18;
		4'h6: cycles_d = 7'd22;
		4'h7: cycles_d = 7'd26;
		4'h8: cycles_d = 7'd30;
		4'h9: cycles_d = 7'd33;
		4'ha: cycles_d = 7'd36;
		4'hb: cycles_d = 7'd38;
		4'hc: cycles_d = 7'd52;
		4'hd: cycles_d = 7'd60;
		4'he: cycles_d = 7'd64;
		default: cycles_d = 7'd80;
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cycles_q <= 7'd0;
		end else begin
			cycles_q <= cycles_d;
		end
	end

endmodule // wait_count_table

// *** verilog/pc_card_timing.v ***
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "pc_card_timing_regs.vh"

// Overview of operation
// (R1) Wait count code 0-15 inserts 3,6,9,12,15,18,22,26,30,33,36,38,52,60,64,80 cycles.
// (R2) Wait count field resets to 1010, giving 36 wait cycles.
// (R3) Wait mask bit 6: 0 lets external wait stretch, 1 ignores it.
// (R4) The wait mask applies even when the wait count is zero.
// (R5) Bits 5 and 4 read as zero; software writes zero there.
// (R6) Address hold after strobe negation is code plus half a cycle.
// (R7) Address hold field resets to 0000, a half-cycle hold.
// (R8) Strobe set-up delay is code plus half a cycle, codes above 0111 prohibited.
// (R9) Unmasked external wait keeps the strobe asserted past the wait count.

module pc_card_timing (
	input wire core_clk,
	input wire arst_n,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	input wire acc_req,
	input wire acc_area,
	input wire acc_write,
	input wire ext_wait_n,
	output reg addr_oe_q,
	output reg rd_n_q,
	output reg we_n_q,
	output reg acc_done_q
);

	// One core clock tick is half an external bus cycle, so every
	// half-cycle figure is an exact number of ticks.
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_SETUP = 5'b00010;
	localparam [4:0] ST_STROBE = 5'b00100;
	localparam [4:0] ST_HOLD = 5'b01000;
	localparam [4:0] ST_DONE = 5'b10000;

	reg [31:0] area5_q;
	reg [31:0] area6_q;
	reg [31:0] area5_d;
	reg [31:0] area6_d;
	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [7:0] cnt_q;
	reg [7:0] cnt_d;
	reg area_q;
	reg area_d;
	reg write_q;
	reg write_d;
	reg wait_meta_q;
	reg wait_sync_q;
	reg [31:0] rdata_d;
	reg addr_oe_d;
	reg rd_n_d;
	reg we_n_d;
	reg done_d;
	wire [31:0] cfg;
	wire [3:0] setup_code;
	wire [3:0] wait_code;
	wire [3:0] hold_code;
	wire wait_masked;
	wire wait_stretch;
	wire [6:0] wait_cycles;

	// Ticks spent in a phase given in half-cycle steps: code n lasts
	// n + 0.5 cycles, which is 2n + 1 ticks; the counter ends at 2n.
	function [7:0] half_steps_end;
		input [3:0] code;
		begin
			half_steps_end = {3'b000, code, 1'b0};
		end
	endfunction

	function [31:0] write_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		begin
			write_merge = (old_val & ~`BUS_TIMING_REG_WRITE_MASK) |
				(new_val & `BUS_TIMING_REG_WRITE_MASK); // (R5)
		end
	endfunction

	assign cfg = area_q ? area6_q : area5_q;
	assign wait_code = cfg[`ACCESS_WAIT_COUNT_MSB:`ACCESS_WAIT_COUNT_LSB];
	assign hold_code = cfg[`ADDR_HOLD_AFTER_STROBE_MSB:`ADDR_HOLD_AFTER_STROBE_LSB]; // (R6)
	// Prohibited set-up codes saturate so a bad write cannot hang the cycle.
	assign setup_code = (cfg[`STROBE_SETUP_DELAY_MSB:`STROBE_SETUP_DELAY_LSB] >
		`STROBE_SETUP_DELAY_MAX) ? `STROBE_SETUP_DELAY_MAX :
		cfg[`STROBE_SETUP_DELAY_MSB:`STROBE_SETUP_DELAY_LSB]; // (R8)
	assign wait_masked = cfg[`EXT_WAIT_MASK_BIT];
	assign wait_stretch = !wait_masked && !wait_sync_q; // (R3)

	wait_count_table u_wait_table (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.code(wait_code),
		.cycles_q(wait_cycles)
	);

	always @* begin
		area5_d = area5_q;
		area6_d = area6_q;
		if (reg_wr && reg_addr == `AREA5_BUS_TIMING_REG_OFS) begin
			area5_d = write_merge(area5_q, reg_wdata);
		end
		if (reg_wr && reg_addr == `AREA6_BUS_TIMING_REG_OFS) begin
			area6_d = write_merge(area6_q, reg_wdata);
		end
	end

	always @* begin
		rdata_d = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
			`AREA5_BUS_TIMING_REG_OFS: rdata_d = area5_q & `BUS_TIMING_REG_WRITE_MASK; // (R5)
			`AREA6_BUS_TIMING_REG_OFS: rdata_d = area6_q & `BUS_TIMING_REG_WRITE_MASK;
			`ACCESS_STATUS_REG_OFS: rdata_d = {24'h000000, 1'b0, !wait_sync_q,
				write_q, area_q, state_q[4:1]};
			default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always @* begin
		state_d = state_q;
		cnt_d = cnt_q + 8'h01;
		area_d = area_q;
		write_d = write_q;
		addr_oe_d = addr_oe_q;
		rd_n_d = 1'b1;
		we_n_d = 1'b1;
		done_d = 1'b0;
		case (state_q)
		ST_IDLE: begin
			cnt_d = 8'h00;
			addr_oe_d = 1'b0;
			if (acc_req) begin
				state_d = ST_SETUP;
				area_d = acc_area;
				write_d = acc_write;
				addr_oe_d = 1'b1;
			end
		end
		ST_SETUP: begin
			if (cnt_q == half_steps_end(setup_code)) begin // (R8)
				state_d = ST_SETUP << 1;
				cnt_d = 8'h00;
				rd_n_d = write_q;
				we_n_d = !write_q;
			end
		end
		ST_STROBE: begin
			rd_n_d = write_q;
			we_n_d = !write_q;
			// Strobe spans one bus cycle plus the wait cycles, counted in ticks.
			if (cnt_q >= {wait_cycles, 1'b1}) begin // (R1)
				cnt_d = cnt_q;
				// The mask is checked here with no regard to the wait count.
				if (!wait_stretch) begin // (R4)
					state_d = ST_HOLD;
					cnt_d = 8'h00;
					rd_n_d = 1'b1;
					we_n_d = 1'b1;
				end // (R9)
			end
		end
		ST_HOLD: begin
			if (cnt_q == half_steps_end(hold_code)) begin // (R6)
				state_d = ST_DONE;
				addr_oe_d = 1'b0;
				done_d = 1'b1;
			end
		end
		ST_DONE: begin
			state_d = ST_IDLE;
			cnt_d = 8'h00;
		end
		default: begin
			state_d = ST_IDLE;
			cnt_d = 8'h00;
			addr_oe_d = 1'b0;
		end
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			area5_q <= `BUS_TIMING_REG_RESET; // (R2) (R7)
			area6_q <= `BUS_TIMING_REG_RESET; // (R2) (R7)
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			area_q <= 1'b0;
			write_q <= 1'b0;
			wait_meta_q <= 1'b1;
			wait_sync_q <= 1'b1;
			reg_rdata_q <= 32'h00000000;
			addr_oe_q <= 1'b0;
			rd_n_q <= 1'b1;
			we_n_q <= 1'b1;
			acc_done_q <= 1'b0;
		end else begin
			area5_q <= area5_d;
			area6_q <= area6_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			area_q <= area_d;
			write_q <= write_d;
			wait_meta_q <= ext_wait_n;
			wait_sync_q <= wait_meta_q;
			reg_rdata_q <= rdata_d;
			addr_oe_q <= addr_oe_d;
			rd_n_q <= rd_n_d;
			we_n_q <= we_n_d;
			acc_done_q <= done_d;
		end
	end

endmodule // pc_card_timing

// *** tb/pc_card_timing_monitor.sv ***
`timescale 1ns/1ps
module pc_card_timing_monitor (
	input wire core_clk,
	input wire arst_n,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_rdata_q,
	input wire acc_req,
	input wire addr_oe_q,
	input wire rd_n_q,
	input wire we_n_q,
	input wire acc_done_q
);
	wire strb = !rd_n_q || !we_n_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
		else $error("read data outside read");
	chk_rsvd_zero: assert property ($past(reg_rd && !reg_addr[3]) |-> reg_rdata_q[5:4] == 2'h0)
		else $error("reserved bits set");
	chk_strobe_addr: assert property (strb |-> addr_oe_q) else $error("strobe alone");
	chk_setup_first: assert property ($rose(strb) |-> $past(addr_oe_q)) else $error("setup");
	chk_hold_after: assert property ($fell(strb) |-> addr_oe_q) else $error("hold");
	chk_min_wait: assert property ($rose(strb) |-> strb [*8]) else $error("short strobe");
	chk_done_release: assert property (acc_done_q |-> !addr_oe_q && $past(addr_oe_q))
		else $error("done without release");
	chk_start_setup: assert property (acc_req && !addr_oe_q && !acc_done_q |=> addr_oe_q && !strb)
		else $error("no start");
	cover property (acc_done_q);
	cover property (!we_n_q);
	cover property (strb [*8] ##1 strb [*8] ##1 strb [*8]);
endmodule // pc_card_timing_monitor
bind pc_card_timing pc_card_timing_monitor i_mon (.core_clk(core_clk), .arst_n(arst_n),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata_q(reg_rdata_q), .acc_req(acc_req),
	.addr_oe_q(addr_oe_q), .rd_n_q(rd_n_q), .we_n_q(we_n_q), .acc_done_q(acc_done_q));

// *** tb/card_model.sv ***
`timescale 1ns/1ps
module card_model (
	input wire core_clk,
	input wire rd_n,
	input wire we_n,
	input wire [7:0] stretch,
	output reg ext_wait_n
);
	reg [7:0] cnt_q = 8'h00;
	reg strb_q = 1'b0;
	// The wait line is pulled up, so an idle card leaves it high.
	always @(posedge core_clk) begin
		strb_q <= !(rd_n && we_n);
		if (!(rd_n && we_n) && !strb_q)
			cnt_q <= stretch;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end
	always @* ext_wait_n = (cnt_q == 8'h00);
endmodule // card_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	reg core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg acc_req = 1'b0, acc_area = 1'b0, acc_write = 1'b0;
	reg [7:0] reg_addr = 8'h00, stretch = 8'h00;
	reg [31:0] reg_wdata = 32'h0;
	wire [31:0] reg_rdata_q;
	wire ext_wait_n, addr_oe_q, rd_n_q, we_n_q, acc_done_q;
	integer fail_count = 0, n_compared = 0, cyc = 0, ls, tot, i, w;
	reg [127:0] tbl = 128'h50403c342624211e1a16120f0c090603;
	pc_card_timing i_pc_card_timing (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.acc_req(acc_req), .acc_area(acc_area), .acc_write(acc_write), .ext_wait_n(ext_wait_n),
		.addr_oe_q(addr_oe_q), .rd_n_q(rd_n_q), .we_n_q(we_n_q), .acc_done_q(acc_done_q));
	card_model i_card_model (.core_clk(core_clk), .rd_n(rd_n_q), .we_n(we_n_q),
		.stretch(stretch), .ext_wait_n(ext_wait_n));
	initial forever #5 core_clk = ~core_clk;
	task conclude;
		begin
			$display("compared %0d mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fail_count = fail_count + 1;
			conclude;
		end
	end
	task check(input [63:0] nm, input [31:0] exp, input [31:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("Error %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge core_clk);
			reg_wr <= 1'b0;
		end
	endtask
	// Read data lives for one cycle only, so it is sampled just after the taking edge.
	task rd(input [7:0] a, input [31:0] exp);
		begin
			@(posedge core_clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			#1 check("rdata", exp, reg_rdata_q);
		end
	endtask
	task acc(input wr_acc, input area);
		begin
			@(posedge core_clk);
			acc_write <= wr_acc;
			acc_area <= area;
			acc_req <= 1'b1;
			@(posedge core_clk);
			acc_req <= 1'b0;
			ls = 0;
			tot = 0;
			#1;
			while (acc_done_q !== 1'b1 && cyc < 10000) begin
				tot = tot + (addr_oe_q === 1'b1);
				ls = ls + ((wr_acc ? we_n_q : rd_n_q) === 1'b0);
				@(posedge core_clk);
				#1;
			end
		end
	endtask
	task s_regs;
		begin
			rd(8'h00, 32'h00000500);
			rd(8'h04, 32'h00000500);
			wr(8'h04, 32'h00003fcf);
			rd(8'h04, 32'h00003fcf);
			rd(8'h0c, 32'h0);
		end
	endtask
	task s_wait;
		for (i = 0; i < 16; i = i + 1) begin
			w = tbl[i*8 +: 8];
			wr(8'h00, {21'h0, i[3:0], 7'h40});
			acc(1'b0, 1'b0);
			check("strobe", 2 * w + 2, ls);
			check("access", 2 * w + 4, tot);
		end
	endtask
	task s_hold;
		begin
			for (i = 0; i < 16; i = i + 5) begin
				wr(8'h04, {17'h0, 8'h70, 3'h4, i[3:0]});
				acc(1'b1, 1'b1);
				check("wstrobe", 8, ls);
				check("waccess", 24 + 2 * i, tot);
			end
			// Status after a write access to area 6: idle, write and area bits set.
			rd(8'h08, 32'h00000030);
		end
	endtask
	task s_ext;
		begin
			wr(8'h00, 32'h0);
			stretch <= 8'h1e;
			acc(1'b0, 1'b0);
			check("stretch", 1, ls >= 30 && ls <= 36);
			wr(8'h00, 32'h40);
			acc(1'b0, 1'b0);
			check("masked", 8, ls);
			stretch <= 8'h00;
		end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		s_regs;
		s_wait;
		s_hold;
		s_ext;
		conclude;
	end
endmodule // testbench
